// >>> flash_seq_defs.vh
// Constants for the serial flash program and erase sequencer
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH
// Opcodes
`define OP_WR_EN    8'h06
`define OP_CE_A     8'h60
`define OP_CE_B     8'hC7
`define OP_PROG1    8'h02
`define OP_PROG2    8'hA2
`define OP_PROG4    8'h32
`define OP_SERASE   8'h44
`define OP_SPROG    8'h42
// Frame phases
`define PH_OP       2'b00
`define PH_ADDR     2'b01
`define PH_DATA     2'b10
`define PH_TAIL     2'b11
// Running operation kinds
`define K_NONE      3'b000
`define K_CE        3'b001
`define K_PROG      3'b010
`define K_SERASE    3'b011
`define K_SPROG     3'b100
// Field and count constants
`define BYTE_BITS   4'h8
`define LAST_ADDR   2'h2
`define PAGE_MASK   10'h0FF
`define SEC_MASK    10'h3FF
`define PAGE_LAST   10'h0FF
`define SEC_LAST    10'h3FF
`define SEC_HI      8'h00
`define SEC_MID     2'h0
`define BLOCKS      7'h40
`define BP_ALL      3'h7
`define CLK_MHZ     100
`endif

// >>> flash_cmd_seq.v
// Program and erase command sequencer of a serial NOR flash
//
// Functional notes
// - Chip erase: lone opcode 60 or C7, then chip select rises.
// - Chip erase rejected unless chip select rises on a byte boundary.
// - Chip erase runs timed; busy flag high, then low, latch cleared.
// - Chip erase only when all five protect bits select no protection.
// - Program 02: three address bytes, data on line 0, latch set.
// - Data past the page end wraps to the page start.
// - Only the final 256 bytes are kept; fewer land at their addresses.
// - Program rejected unless chip select rises after a whole data byte.
// - Program runs timed; busy flag high, then low, latch cleared.
// - Program into a protected page is not carried out.
// - Dual program A2: address on line 0, data two bits per clock.
// - Quad program 32: address on line 0, data four bits per clock.
// - Three 1024-byte secure areas, each erased and programmed alone.
// - Secure erase 44: address selects area 1 to 3, low bits ignored.
// - Secure erase runs only if chip select rises on a byte boundary.
// - Secure erase runs for the sector erase time with busy flag high.
// - Locked secure area ignores erase commands.
// - Secure program 42: address selects area and byte, 1 to 1024 bytes.
// - Secure program runs for the program time; ignored when locked.
`timescale 1ns/10ps
module flash_cmd_seq #(
    parameter [31:0] ARRAY_ERASE_US  = 32'd20000, // Whole array erase
    parameter [31:0] PROGRAM_US      = 32'd600,   // Page program
    parameter [31:0] SECTOR_ERASE_US = 32'd4000   // Secure area erase
) (
    input  wire         clock,                // System clock
    input  wire         rst,                  // Synchronous reset
    input  wire         chipSelN,             // Chip select pin
    input  wire         serialClk,            // Serial clock pin
    input  wire [3:0]   ioIn,                 // Data pins IO3..IO0
    input  wire [4:0]   protectBits,          // Block protect select
    input  wire         quadEnableBit,        // Quad enable
    input  wire [2:0]   secureAreaLockBits,   // Secure area locks
    output reg          busyFlag_ff,          // Self-timed cycle running
    output reg          writeEnableLatch_ff,  // Write enable latch
    output reg          memWrite_ff,          // Array byte write strobe
    output reg  [23:0]  memAddr_ff,           // Write or erase address
    output reg  [7:0]   memData_ff,           // Byte to write
    output reg          chipErase_ff,         // Whole array erase pulse
    output reg          secureErase_ff,       // Secure area erase pulse
    output reg          secureSpace_ff        // Address is a secure area
);
`include "flash_seq_defs.vh"

localparam [31:0] CE_CYC = ARRAY_ERASE_US * `CLK_MHZ;
localparam [31:0] PRG_CYC = PROGRAM_US * `CLK_MHZ;
localparam [31:0] SE_CYC = SECTOR_ERASE_US * `CLK_MHZ;

//------------------------------------------------------------
// Functions
//------------------------------------------------------------
// Shift one lane group into a byte
function [7:0] shiftIn;
    input [7:0] sh;
    input [3:0] io;
    input [2:0] w;
    begin
        case (w)
            3'h2:    shiftIn = {sh[5:0], io[1:0]};
            3'h4:    shiftIn = {sh[3:0], io[3:0]};
            default: shiftIn = {sh[6:0], io[0]};
        endcase
    end
endfunction

// Top or bottom group of 64K blocks guarded by the protect bits
function isProtected;
    input [23:0] a;
    input [4:0]  bp;
    reg   [5:0]  blk;
    reg   [6:0]  limit;
    begin
        blk   = bp[3] ? ~a[21:16] : a[21:16];
        limit = `BLOCKS - (7'h01 << (bp[2:0] - 3'h1));
        isProtected = (bp[2:0] == `BP_ALL) ||
                      ((bp[2:0] != 3'h0) && ({1'b0, blk} >= limit));
    end
endfunction

// Secure area address shape check
function secValid;
    input [23:0] a;
    begin
        secValid = (a[23:16] == `SEC_HI) && (a[11:10] == `SEC_MID) &&
                   (a[15:14] == 2'h0) && (a[13:12] != 2'h0);
    end
endfunction

// Lock bit of the addressed secure area
function secLocked;
    input [23:0] a;
    input [2:0]  lb;
    begin
        secLocked = lb[a[13:12] - 2'h1];
    end
endfunction

//------------------------------------------------------------
// Pin synchronisers and filter
//------------------------------------------------------------
reg  [5:0] syncA_ff;
reg  [5:0] syncB_ff;
reg  [5:0] syncC_ff;
reg  [5:0] filt_ff;
reg        prevCs_ff;
reg        prevSclk_ff;
wire [5:0] nxt_filt;

// A pin change counts once the second and third stages agree
assign nxt_filt = (~(syncB_ff ^ syncC_ff) & syncC_ff) |
                  ((syncB_ff ^ syncC_ff) & filt_ff);

// Three-stage sampling of the link pins
always @(posedge clock) begin
    if (rst) begin
        syncA_ff    <= 6'h20;
        syncB_ff    <= 6'h20;
        syncC_ff    <= 6'h20;
        filt_ff     <= 6'h20;
        prevCs_ff   <= 1'b1;
        prevSclk_ff <= 1'b0;
    end else begin
        syncA_ff    <= {chipSelN, serialClk, ioIn};
        syncB_ff    <= syncA_ff;
        syncC_ff    <= syncB_ff;
        filt_ff     <= nxt_filt;
        prevCs_ff   <= filt_ff[5];
        prevSclk_ff <= filt_ff[4];
    end
end

wire csFall    = ~filt_ff[5] & prevCs_ff;
wire csRise    = filt_ff[5] & ~prevCs_ff;
wire sclkRise  = filt_ff[4] & ~prevSclk_ff & ~filt_ff[5];

//------------------------------------------------------------
// Frame receiver
//------------------------------------------------------------
reg  [1:0]  phase_ff;
reg  [3:0]  bitCnt_ff;
reg  [1:0]  addrCnt_ff;
reg  [7:0]  shift_ff;
reg  [7:0]  cmd_ff;
reg  [23:0] addr_ff;
reg  [9:0]  ptr_ff;
reg         dataSeen_ff;
reg         overrun_ff;
reg         frameBusy_ff;
reg  [1023:0] valid_ff;
reg  [7:0]  dataBuf [0:1023];

wire        isSec    = (cmd_ff == `OP_SPROG);
wire [9:0]  wrapMask = isSec ? `SEC_MASK : `PAGE_MASK;
// Lane width of the current bit group
wire [2:0]  laneW = (phase_ff != `PH_DATA) ? 3'h1 :
                    (cmd_ff == `OP_PROG2) ? 3'h2 :
                    (cmd_ff == `OP_PROG4) ? 3'h4 : 3'h1;
wire [7:0]  nb       = shiftIn(shift_ff, filt_ff[3:0], laneW);
wire [3:0]  bitsNext = bitCnt_ff + {1'b0, laneW};
wire        byteDone = (bitsNext == `BYTE_BITS);
wire        takeBit  = sclkRise & ~frameBusy_ff;
wire        needAddr = (cmd_ff == `OP_PROG1) || (cmd_ff == `OP_PROG2) ||
                       (cmd_ff == `OP_PROG4) || (cmd_ff == `OP_SERASE) ||
                       isSec;
wire        hasData  = needAddr && (cmd_ff != `OP_SERASE);
wire        opNeedAddr = (nb == `OP_PROG1) || (nb == `OP_PROG2) ||
                       (nb == `OP_PROG4) || (nb == `OP_SERASE) ||
                       (nb == `OP_SPROG);

// Shift bits, count bytes and walk the phases of a frame
always @(posedge clock) begin
    if (rst) begin
        phase_ff     <= `PH_OP;
        bitCnt_ff    <= 4'h0;
        addrCnt_ff   <= 2'h0;
        shift_ff     <= 8'h00;
        cmd_ff       <= 8'h00;
        addr_ff      <= 24'h000000;
        ptr_ff       <= 10'h000;
        dataSeen_ff  <= 1'b0;
        overrun_ff   <= 1'b0;
        frameBusy_ff <= 1'b0;
        valid_ff     <= {1024{1'b0}};
    end else if (csFall) begin
        phase_ff     <= `PH_OP;
        bitCnt_ff    <= 4'h0;
        addrCnt_ff   <= 2'h0;
        dataSeen_ff  <= 1'b0;
        overrun_ff   <= 1'b0;
        frameBusy_ff <= busyFlag_ff;
        if (!busyFlag_ff) begin
            valid_ff <= {1024{1'b0}};
        end
    end else if (takeBit) begin
        shift_ff  <= nb;
        bitCnt_ff <= byteDone ? 4'h0 : bitsNext;
        if (byteDone) begin
            case (phase_ff)
                `PH_OP: begin
                    cmd_ff   <= nb;
                    phase_ff <= opNeedAddr ? `PH_ADDR : `PH_TAIL;
                end
                `PH_ADDR: begin
                    addr_ff    <= {addr_ff[15:0], nb};
                    addrCnt_ff <= addrCnt_ff + 2'h1;
                    ptr_ff     <= {addr_ff[1:0], nb} & wrapMask;
                    if (addrCnt_ff == `LAST_ADDR) begin
                        phase_ff <= hasData ? `PH_DATA : `PH_TAIL;
                    end
                end
                `PH_DATA: begin
                    valid_ff[ptr_ff] <= 1'b1;
                    ptr_ff      <= (ptr_ff + 10'h001) & wrapMask;
                    dataSeen_ff <= 1'b1;
                end
                default: begin
                    overrun_ff <= 1'b1;
                end
            endcase
        end
    end
end

// Data bytes overwrite earlier ones at the same position
always @(posedge clock) begin
    if (takeBit && byteDone && phase_ff == `PH_DATA) begin
        dataBuf[ptr_ff] <= nb;
    end
end

//------------------------------------------------------------
// Command check at chip select rise and timed cycle
//------------------------------------------------------------
reg  [2:0]  kind_ff;
reg  [31:0] timer_ff;
reg  [9:0]  scanIdx_ff;
reg         scanDone_ff;

// Frame ends cleanly on a byte boundary with nothing extra
wire frameOk = csRise & ~frameBusy_ff & ~overrun_ff &
               (bitCnt_ff == 4'h0);
wire tailOk  = frameOk & (phase_ff == `PH_TAIL);
wire dataOk  = frameOk & (phase_ff == `PH_DATA) & dataSeen_ff &
               writeEnableLatch_ff;
wire ceGo    = tailOk & writeEnableLatch_ff &
               ((cmd_ff == `OP_CE_A) || (cmd_ff == `OP_CE_B)) &
               (protectBits == 5'h00);
wire progGo  = dataOk & ((cmd_ff == `OP_PROG1) || (cmd_ff == `OP_PROG2) ||
               ((cmd_ff == `OP_PROG4) && quadEnableBit)) &
               ~isProtected(addr_ff, protectBits);
wire seGo    = tailOk & writeEnableLatch_ff & (cmd_ff == `OP_SERASE) &
               secValid(addr_ff) &
               ~secLocked(addr_ff, secureAreaLockBits);
wire spGo    = dataOk & isSec & secValid(addr_ff) &
               ~secLocked(addr_ff, secureAreaLockBits);
wire latchGo = tailOk & (cmd_ff == `OP_WR_EN);
wire [9:0] scanLast = (kind_ff == `K_SPROG) ? `SEC_LAST : `PAGE_LAST;

// Start, run and finish the self-timed cycles
always @(posedge clock) begin
    if (rst) begin
        busyFlag_ff         <= 1'b0;
        writeEnableLatch_ff <= 1'b0;
        kind_ff             <= `K_NONE;
        timer_ff            <= 32'h00000000;
        scanIdx_ff          <= 10'h000;
        scanDone_ff         <= 1'b1;
        memWrite_ff         <= 1'b0;
        memAddr_ff          <= 24'h000000;
        memData_ff          <= 8'h00;
        chipErase_ff        <= 1'b0;
        secureErase_ff      <= 1'b0;
        secureSpace_ff      <= 1'b0;
    end else begin
        chipErase_ff   <= 1'b0;
        secureErase_ff <= 1'b0;
        memWrite_ff    <= 1'b0;
        if (!busyFlag_ff) begin
            if (latchGo) begin
                writeEnableLatch_ff <= 1'b1;
            end
            if (ceGo) begin
                busyFlag_ff    <= 1'b1;
                kind_ff        <= `K_CE;
                timer_ff       <= CE_CYC;
                chipErase_ff   <= 1'b1;
                memAddr_ff     <= 24'h000000;
                secureSpace_ff <= 1'b0;
            end else if (seGo) begin
                busyFlag_ff    <= 1'b1;
                kind_ff        <= `K_SERASE;
                timer_ff       <= SE_CYC;
                secureErase_ff <= 1'b1;
                memAddr_ff     <= {addr_ff[23:10], 10'h000};
                secureSpace_ff <= 1'b1;
            end else if (progGo || spGo) begin
                busyFlag_ff    <= 1'b1;
                kind_ff        <= spGo ? `K_SPROG : `K_PROG;
                timer_ff       <= PRG_CYC;
                scanIdx_ff     <= 10'h000;
                scanDone_ff    <= 1'b0;
                secureSpace_ff <= spGo;
            end
        end else begin
            if (timer_ff != 32'h00000000) begin
                timer_ff <= timer_ff - 32'h00000001;
            end
            // Hand buffered bytes to the array one per cycle
            if (!scanDone_ff) begin
                memWrite_ff <= valid_ff[scanIdx_ff];
                memData_ff  <= dataBuf[scanIdx_ff];
                memAddr_ff  <= (kind_ff == `K_SPROG) ?
                               {addr_ff[23:10], scanIdx_ff} :
                               {addr_ff[23:8], scanIdx_ff[7:0]};
                scanIdx_ff  <= scanIdx_ff + 10'h001;
                scanDone_ff <= (scanIdx_ff == scanLast);
            end
            // Cycle done: busy drops and the latch clears
            if (timer_ff == 32'h00000000 && scanDone_ff) begin
                busyFlag_ff         <= 1'b0;
                writeEnableLatch_ff <= 1'b0;
                kind_ff             <= `K_NONE;
            end
        end
    end
end

endmodule // flash_cmd_seq

// >>> flash_cmd_seq_assertions.sv
// Checker of the flash command sequencer outputs
`timescale 1ns/10ps
module flash_cmd_seq_checker #(
    parameter [31:0] ARRAY_ERASE_US  = 32'd20000, // Array erase
    parameter [31:0] PROGRAM_US      = 32'd600,   // Page program
    parameter [31:0] SECTOR_ERASE_US = 32'd4000   // Area erase
) (
    input wire        clock,               // Clock
    input wire        rst,                 // Reset
    input wire        chipSelN,            // Chip select
    input wire        serialClk,           // Serial clock
    input wire [3:0]  ioIn,                // Data pins
    input wire [4:0]  protectBits,         // Protect select
    input wire        quadEnableBit,       // Quad enable
    input wire [2:0]  secureAreaLockBits,  // Area locks
    input wire        busyFlag_ff,         // Busy
    input wire        writeEnableLatch_ff, // Latch
    input wire        memWrite_ff,         // Write strobe
    input wire [23:0] memAddr_ff,          // Address
    input wire [7:0]  memData_ff,          // Data
    input wire        chipErase_ff,        // Array erase
    input wire        secureErase_ff,      // Area erase
    input wire        secureSpace_ff       // Area target
);
    localparam int TA = int'(ARRAY_ERASE_US) * 100;
    localparam int TP = int'(PROGRAM_US) * 100;
    localparam int TS = int'(SECTOR_ERASE_US) * 100;
    localparam int MINC = (TP < TS ? TP : TS) < TA ? (TP < TS ? TP : TS) : TA;
    localparam int MAXC = TA + TP + TS + 1030;
    logic [31:0] busyCnt_ff;
    // Length of the current self-timed cycle
    always @(posedge clock) begin
        if (rst || !busyFlag_ff) busyCnt_ff <= 32'h0;
        else busyCnt_ff <= busyCnt_ff + 32'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    erase_unprotected_a: assert property (
        chipErase_ff |-> protectBits == 5'h00) else $error("erase protected");
    erase_starts_busy_a: assert property (
        chipErase_ff |-> busyFlag_ff && !$past(busyFlag_ff))
        else $error("erase pulse off busy start");
    busy_needs_latch_a: assert property (
        $rose(busyFlag_ff) |-> $past(writeEnableLatch_ff))
        else $error("busy without latch");
    busy_after_cs_a: assert property (
        $rose(busyFlag_ff) |-> chipSelN && $past(chipSelN, 3))
        else $error("busy before select release");
    latch_clear_end_a: assert property (
        $fell(busyFlag_ff) |-> !writeEnableLatch_ff) else $error("latch kept");
    busy_min_time_a: assert property (
        $fell(busyFlag_ff) |-> busyCnt_ff >= MINC) else $error("cycle short");
    busy_max_time_a: assert property (
        busyCnt_ff <= MAXC) else $error("cycle too long");
    write_in_cycle_a: assert property (
        memWrite_ff |-> busyFlag_ff && !chipErase_ff) else $error("stray write");
    write_unprotected_a: assert property (
        memWrite_ff && !secureSpace_ff |-> protectBits[2:0] != 3'h7)
        else $error("write into protected page");
    page_ascending_a: assert property (
        memWrite_ff && !secureSpace_ff ##1 memWrite_ff |->
        memAddr_ff[23:8] == $past(memAddr_ff[23:8]) &&
        memAddr_ff[7:0] > $past(memAddr_ff[7:0])) else $error("page scan");
    secure_unlocked_a: assert property (
        (memWrite_ff && secureSpace_ff || secureErase_ff) |->
        (secureAreaLockBits & (3'h1 << (memAddr_ff[13:12] - 2'h1))) == 3'h0)
        else $error("locked area changed");
    secure_addr_ok_a: assert property (
        secureErase_ff |-> secureSpace_ff && busyFlag_ff &&
        memAddr_ff[23:16] == 8'h00 && memAddr_ff[11:0] == 12'h000 &&
        memAddr_ff[15:12] inside {4'h1, 4'h2, 4'h3}) else $error("area addr");
endmodule // flash_cmd_seq_checker
bind flash_cmd_seq flash_cmd_seq_checker #(
    .ARRAY_ERASE_US(ARRAY_ERASE_US), .PROGRAM_US(PROGRAM_US),
    .SECTOR_ERASE_US(SECTOR_ERASE_US)) chk (.clock(clock), .rst(rst),
    .chipSelN(chipSelN), .serialClk(serialClk), .ioIn(ioIn),
    .protectBits(protectBits), .quadEnableBit(quadEnableBit),
    .secureAreaLockBits(secureAreaLockBits), .busyFlag_ff(busyFlag_ff),
    .writeEnableLatch_ff(writeEnableLatch_ff), .memWrite_ff(memWrite_ff),
    .memAddr_ff(memAddr_ff), .memData_ff(memData_ff),
    .chipErase_ff(chipErase_ff), .secureErase_ff(secureErase_ff),
    .secureSpace_ff(secureSpace_ff));

// >>> flash_host_model.sv
// Host controller model driving the serial flash pins
`timescale 1ns/10ps
module flash_host_model (
    input  wire        clock, // System clock
    output logic       csN,   // Chip select, active low
    output logic       sck,   // Serial clock, idle low
    output logic [3:0] io     // Data lines IO3..IO0
);
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        io  = 4'h0;
    end
    // Data byte i of a stream, distinct beyond 256 bytes
    function automatic [7:0] gb(input [7:0] f, input int i);
        gb = f + 8'(3 * i) + 8'(i >> 8);
    endfunction
    // n bits of b on w lines, MSB first, 170 ns serial clock
    task automatic shift(input [7:0] b, input int n, input int w);
        logic [7:0] s;
        s = b;
        for (int i = 0; i < n; i += w) begin
            @(negedge clock);
            io = w == 4 ? s[7:4] : w == 2 ? {2'b00, s[7:6]} : {3'b000, s[7]};
            s = s << w;
            repeat (8) @(negedge clock);
            sck = 1'b1;
            repeat (8) @(negedge clock);
            sck = 1'b0;
        end
    endtask
    // One frame: opcode, na address bytes, nd data bytes, ex loose bits
    task automatic frame(input [7:0] op, input [23:0] ad, input int na,
                         input int nd, input int w, input int ex);
        @(negedge clock);
        csN = 1'b0; // Held low for the whole transfer
        shift(op, 8, 1);
        for (int k = 0; k < na; k++) shift(ad[23-8*k -: 8], 8, 1);
        for (int k = 0; k < nd; k++) shift(gb(8'h5A, k), 8, w);
        if (ex > 0) shift(8'hFF, ex, 1);
        repeat (8) @(negedge clock);
        csN = 1'b1;
        io = ~io; // Released lines show the inverse of the last value
        repeat (8) @(negedge clock);
    endtask
endmodule // flash_host_model

// >>> serial_flash_program_erase_cmds_bench.sv
// Testbench of the flash program and erase command sequencer
`timescale 1ns/10ps
module serial_flash_program_erase_cmds_bench;
    logic        clock, rst, qe;
    logic [4:0]  bp;
    logic [2:0]  lock;
    wire         csN, sck, busy, write_enable_latch, mw, ce, se, ss;
    wire  [3:0]  io;
    wire  [23:0] ma;
    wire  [7:0]  md;
    logic [32:0] wq[$];
    logic [24:0] seAd;
    int          n_mismatch = 0, num_checks = 0, nCe, nSe;
    flash_cmd_seq #(.ARRAY_ERASE_US(32'd11), .PROGRAM_US(32'd11),
        .SECTOR_ERASE_US(32'd11)) dut (.clock(clock), .rst(rst),
        .chipSelN(csN), .serialClk(sck), .ioIn(io), .protectBits(bp),
        .quadEnableBit(qe), .secureAreaLockBits(lock), .busyFlag_ff(busy),
        .writeEnableLatch_ff(write_enable_latch), .memWrite_ff(mw), .memAddr_ff(ma),
        .memData_ff(md), .chipErase_ff(ce), .secureErase_ff(se),
        .secureSpace_ff(ss));
    flash_host_model host (.clock(clock), .csN(csN), .sck(sck), .io(io));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Collect written bytes and erase pulses
    always @(posedge clock) begin
        if (mw === 1'b1) wq.push_back({ss, ma, md});
        if (ce === 1'b1) nCe++;
        if (se === 1'b1) begin
            nSe++;
            seAd = {ss, ma};
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Latch set, command frame, then busy and latch outcome
    task automatic cmd(input [7:0] op, input [23:0] ad, input int na, nd,
                       input int w, ex, input logic eb);
        int t;
        wq.delete();
        nCe = 0;
        nSe = 0;
        host.frame(8'h06, 24'h0, 0, 0, 1, 0);
        chk("latch set", 33'(1'b1), 33'(write_enable_latch));
        host.frame(op, ad, na, nd, w, ex);
        chk("busy", 33'(eb), 33'(busy));
        t = 0;
        while (busy === 1'b1 && t < 3000) begin
            @(negedge clock);
            t++;
        end
        chk("busy end", 33'(1'b0), 33'(busy));
        chk("latch after", 33'(!eb), 33'(write_enable_latch));
        if (!eb) begin
            chk("refused", 33'h0, 33'(wq.size() + nCe + nSe));
        end
    endtask
    // Written bytes against positions and the last data sent
    task automatic expw(input [23:0] a, input int sz, n, input logic sp);
        int k;
        chk("count", 33'(n < sz ? n : sz), 33'(wq.size()));
        foreach (wq[i]) begin
            k = int'(wq[i][17:8] - a[9:0]) & (sz - 1);
            while (k + sz < n) k += sz;
            chk("write", {sp, (a & ~24'(sz - 1)) | ((a + 24'(k)) &
                24'(sz - 1)), host.gb(8'h5A, k)}, wq[i]);
        end
    endtask
    initial begin
        rst = 1'b1;
        qe = 1'b0;
        bp = 5'h00;
        lock = 3'h0;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        repeat (8) @(negedge clock);
        chk("idle", 33'h0, 33'({busy, write_enable_latch, mw, ce, se, ss}));
        cmd(8'h60, 24'h0, 0, 0, 1, 3, 1'b0);
        bp = 5'h01;
        cmd(8'hC7, 24'h0, 0, 0, 1, 0, 1'b0);
        bp = 5'h10;
        cmd(8'h60, 24'h0, 0, 0, 1, 0, 1'b0);
        bp = 5'h00;
        for (int i = 0; i < 2; i++) begin
            cmd(i == 0 ? 8'h60 : 8'hC7, 24'h0, 0, 0, 1, 0, 1'b1);
            chk("erase pulses", 33'h1, 33'(nCe));
        end
        cmd(8'h02, 24'h0412FE, 3, 3, 1, 0, 1'b1);
        expw(24'h0412FE, 256, 3, 1'b0);
        cmd(8'h02, 24'h0412FE, 3, 1, 1, 4, 1'b0);
        bp = 5'h07;
        cmd(8'h02, 24'h041200, 3, 1, 1, 0, 1'b0);
        bp = 5'h00;
        cmd(8'hA2, 24'h000010, 3, 2, 2, 0, 1'b1);
        expw(24'h000010, 256, 2, 1'b0);
        cmd(8'h32, 24'h0700A0, 3, 1, 4, 0, 1'b0);
        qe = 1'b1; // Quad enable before quad program
        cmd(8'h32, 24'h0700A0, 3, 258, 4, 0, 1'b1);
        expw(24'h0700A0, 256, 258, 1'b0);
        cmd(8'h44, 24'h002155, 3, 0, 1, 0, 1'b1);
        chk("area erase", {1'b1, 24'h002000, 8'h01}, {seAd, 8'(nSe)});
        cmd(8'h44, 24'h004000, 3, 0, 1, 0, 1'b0);
        cmd(8'h44, 24'h003000, 0, 0, 1, 0, 1'b0);
        lock = 3'h2;
        cmd(8'h44, 24'h002000, 3, 0, 1, 0, 1'b0);
        cmd(8'h42, 24'h0023FE, 3, 2, 1, 0, 1'b0);
        cmd(8'h42, 24'h0033FE, 3, 3, 1, 0, 1'b1);
        expw(24'h0033FE, 1024, 3, 1'b1);
        stop_test();
    end
    initial begin
        repeat (80000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end
endmodule // serial_flash_program_erase_cmds_bench
